/* File: inc/tit_pkg.sv */
// shared constants and carrier types for the triple interval timer
package tit_pkg;

  // counter geometry
  localparam int NUM_CTR = 3;
  localparam int CTR_W = 16;

  // port select values on the processor bus
  localparam logic [1:0] PORT_CTR0 = 2'h0;
  localparam logic [1:0] PORT_CTR1 = 2'h1;
  localparam logic [1:0] PORT_CTR2 = 2'h2;
  localparam logic [1:0] PORT_CTRL = 2'h3;

  // counter select value that the control word treats as invalid
  localparam logic [1:0] SEL_INVALID = 2'h3;

  // transfer format field codes
  localparam logic [1:0] FMT_LATCH = 2'h0;
  localparam logic [1:0] FMT_LSB = 2'h1;
  localparam logic [1:0] FMT_MSB = 2'h2;
  localparam logic [1:0] FMT_WORD = 2'h3;

  // decade limits for decimal counting
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [3:0] BCD_ZERO = 4'h0;

  // control word layout, most significant field first
  typedef struct packed {
    logic [1:0] counter_select_field;
    logic [1:0] transfer_format_field;
    logic [2:0] mode;
    logic bcd;
  } tit_ctrl_word_t;

  // processor bus pins taken as one group
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [1:0] port_select;
    logic [7:0] data;
  } tit_bus_t;

  // reset values
  localparam logic [CTR_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [2:0] MODE_RST = 3'h0;

endpackage

/* File: src/tit_timer.sv */
// three channel interval timer behind an 8-bit processor port
`timescale 1ns/100ps

// Function
// (RULE_01) three independent sixteen-bit down counters
// (RULE_02) each counter binary or decimal per control
// (RULE_03) counter clock from static to 4 MHz
// (RULE_04) port select 11 writes control word
// (RULE_05) control word sets mode, radix, load format
// (RULE_06) mode governs gate use and output
// (RULE_07) read strobe drives selected counter onto bus
// (RULE_08) write strobe takes mode or count data
// (RULE_09) select 00/01/10 loads counter 0/1/2
// (RULE_10) read at select 11 floats bus
// (RULE_11) deselected chip ignores bus, counters run
// (RULE_12) no strobe means bus floats
// (RULE_13) counters readable while running, undisturbed
// (RULE_14) output line signals time-out completion
// (RULE_15) control word field positions fixed
// (RULE_16) format: latch, msb, lsb, lsb then msb
// (RULE_17) radix bit: binary or four decades
// (RULE_18) counter events on own clock falling edge
// (RULE_19) software programs mode before loading count
// (RULE_20) bus access never corrupts running counter
module tit_timer
(
  // reference clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // processor bus
  input wire tit_pkg::tit_bus_t i_bus,
  output logic [7:0] o_data,
  output logic o_data_oe,
  // counter channels
  input wire logic [tit_pkg::NUM_CTR-1:0] i_cnt_clk,
  input wire logic [tit_pkg::NUM_CTR-1:0] i_gate,
  output logic [tit_pkg::NUM_CTR-1:0] o_cnt_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // state types

  typedef struct packed {
    logic [2:0] mode;
    logic bcd;
    logic [1:0] fmt;
    logic [tit_pkg::CTR_W-1:0] count;
    logic [tit_pkg::CTR_W-1:0] reload;
    logic [tit_pkg::CTR_W-1:0] latch;
    logic latched;
    logic rd_hi;
    logic wr_hi;
    logic pend;
    logic trig;
    logic armed;
    logic out;
  } tit_cnt_t;

  typedef struct packed {
    tit_cnt_t [tit_pkg::NUM_CTR-1:0] ctr;
    tit_pkg::tit_bus_t bus_s1;
    tit_pkg::tit_bus_t bus_s2;
    tit_pkg::tit_bus_t bus_prev;
    logic [tit_pkg::NUM_CTR-1:0] clk_s1;
    logic [tit_pkg::NUM_CTR-1:0] clk_s2;
    logic [tit_pkg::NUM_CTR-1:0] clk_prev;
    logic [tit_pkg::NUM_CTR-1:0] gate_s1;
    logic [tit_pkg::NUM_CTR-1:0] gate_s2;
    logic [tit_pkg::NUM_CTR-1:0] gate_prev;
    logic [7:0] rdata;
  } tit_state_t;

  tit_state_t st;
  tit_state_t next_st;
  logic [tit_pkg::NUM_CTR-1:0] ev;
  logic wr_done;
  logic rd_done;
  tit_pkg::tit_ctrl_word_t cw;
  logic [1:0] wsel;
  logic [tit_pkg::CTR_W-1:0] dn;
  logic [tit_pkg::CTR_W-1:0] rv;
  tit_cnt_t rc;

  ////////////////////////////////////////////////////////////////////////////////
  // one decrement step, binary or decade by decade

  function automatic logic [tit_pkg::CTR_W-1:0] f_dec(
    input logic [tit_pkg::CTR_W-1:0] v,
    input logic bcd
  );
    logic [tit_pkg::CTR_W-1:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd)
    begin
      r = v - 16'h0001;
    end
    else
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (borrow)
        begin
          if (v[4*k +: 4] == tit_pkg::BCD_ZERO)
          begin
            r[4*k +: 4] = tit_pkg::BCD_NINE; // decade wraps, borrow on
          end
          else
          begin
            r[4*k +: 4] = v[4*k +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r; // RULE_17
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_st = st;
    // two-stage synchronisers, third stage is the edge reference
    next_st.bus_s1 = i_bus;
    next_st.bus_s2 = st.bus_s1;
    next_st.bus_prev = st.bus_s2;
    next_st.clk_s1 = i_cnt_clk; // RULE_03
    next_st.clk_s2 = st.clk_s1;
    next_st.clk_prev = st.clk_s2;
    next_st.gate_s1 = i_gate;
    next_st.gate_s2 = st.gate_s1;
    next_st.gate_prev = st.gate_s2;
    ev = st.clk_prev & ~st.clk_s2; // RULE_18
    dn = tit_pkg::COUNT_RST;
    // strobe trailing edges with chip selected
    wr_done = !st.bus_prev.wr_n && st.bus_s2.wr_n && !st.bus_prev.cs_n; // RULE_08 RULE_11
    rd_done = !st.bus_prev.rd_n && st.bus_s2.rd_n && !st.bus_prev.cs_n; // RULE_11
    cw = st.bus_prev.data; // RULE_15
    wsel = st.bus_prev.port_select;

    // counter side, one falling edge of each channel clock at a time
    for (int i = 0; i < tit_pkg::NUM_CTR; i++)
    begin
      if (st.gate_s2[i] && !st.gate_prev[i])
      begin
        next_st.ctr[i].trig = 1'b1; // gate rise held for the next edge
      end
      if (ev[i])
      begin
        next_st.ctr[i].trig = 1'b0;
        dn = f_dec(st.ctr[i].count, st.ctr[i].bcd); // RULE_02
        unique case (st.ctr[i].mode) // RULE_06
          3'h0, 3'h4:
          begin
            // terminal-count interrupt and software strobe
            if (st.ctr[i].pend)
            begin
              next_st.ctr[i].count = st.ctr[i].reload;
              next_st.ctr[i].armed = 1'b1;
              next_st.ctr[i].pend = 1'b0;
              next_st.ctr[i].out = st.ctr[i].mode[2];
            end
            else if (st.ctr[i].armed && st.gate_s2[i])
            begin
              next_st.ctr[i].count = dn; // RULE_01
              if (!st.ctr[i].mode[2] && dn == tit_pkg::COUNT_RST)
              begin
                next_st.ctr[i].out = 1'b1; // RULE_14
              end
              if (st.ctr[i].mode[2])
              begin
                next_st.ctr[i].out = (dn != tit_pkg::COUNT_RST);
                next_st.ctr[i].armed = (st.ctr[i].count != tit_pkg::COUNT_RST);
              end
            end
          end
          3'h1, 3'h5:
          begin
            // gate-triggered one-shot and hardware strobe
            if (st.ctr[i].trig)
            begin
              next_st.ctr[i].count = st.ctr[i].reload;
              next_st.ctr[i].armed = 1'b1;
              next_st.ctr[i].pend = 1'b0;
              next_st.ctr[i].out = st.ctr[i].mode[2];
            end
            else if (st.ctr[i].armed)
            begin
              next_st.ctr[i].count = dn;
              if (!st.ctr[i].mode[2])
              begin
                next_st.ctr[i].out = (dn == tit_pkg::COUNT_RST);
                next_st.ctr[i].armed = (dn != tit_pkg::COUNT_RST);
              end
              else
              begin
                next_st.ctr[i].out = (dn != tit_pkg::COUNT_RST);
                next_st.ctr[i].armed = (st.ctr[i].count != tit_pkg::COUNT_RST);
              end
            end
          end
          default:
          begin
            // rate generator and square wave, gate low holds output high
            if (!st.gate_s2[i])
            begin
              next_st.ctr[i].out = 1'b1;
            end
            else if (st.ctr[i].trig || (st.ctr[i].pend && !st.ctr[i].armed))
            begin
              next_st.ctr[i].count = st.ctr[i].reload;
              next_st.ctr[i].armed = 1'b1;
              next_st.ctr[i].pend = 1'b0;
              next_st.ctr[i].out = 1'b1;
            end
            else if (st.ctr[i].armed && !st.ctr[i].mode[0])
            begin
              // low for one clock period before each reload
              if (st.ctr[i].count == 16'h0001)
              begin
                next_st.ctr[i].count = st.ctr[i].reload;
                next_st.ctr[i].out = 1'b1;
                next_st.ctr[i].pend = 1'b0;
              end
              else
              begin
                next_st.ctr[i].count = dn;
                next_st.ctr[i].out = (dn != 16'h0001);
              end
            end
            else if (st.ctr[i].armed)
            begin
              // two steps per edge, output flips at each half period
              if (st.ctr[i].count <= 16'h0002)
              begin
                next_st.ctr[i].count = st.ctr[i].reload;
                next_st.ctr[i].out = !st.ctr[i].out;
                next_st.ctr[i].pend = 1'b0;
              end
              else
              begin
                next_st.ctr[i].count = f_dec(dn, st.ctr[i].bcd);
              end
            end
          end
        endcase
      end
    end

    // bus writes land after counter updates so a new load is never lost
    if (wr_done) // RULE_20
    begin
      if (wsel == tit_pkg::PORT_CTRL) // RULE_04
      begin
        if (cw.counter_select_field != tit_pkg::SEL_INVALID)
        begin
          if (cw.transfer_format_field == tit_pkg::FMT_LATCH) // RULE_16
          begin
            next_st.ctr[cw.counter_select_field].latch =
              next_st.ctr[cw.counter_select_field].count; // RULE_13
            next_st.ctr[cw.counter_select_field].latched = 1'b1;
            next_st.ctr[cw.counter_select_field].rd_hi = 1'b0;
          end
          else
          begin
            next_st.ctr[cw.counter_select_field].mode = cw.mode; // RULE_05
            next_st.ctr[cw.counter_select_field].bcd = cw.bcd;
            next_st.ctr[cw.counter_select_field].fmt = cw.transfer_format_field;
            next_st.ctr[cw.counter_select_field].armed = 1'b0;
            next_st.ctr[cw.counter_select_field].pend = 1'b0;
            next_st.ctr[cw.counter_select_field].latched = 1'b0;
            next_st.ctr[cw.counter_select_field].rd_hi = 1'b0;
            next_st.ctr[cw.counter_select_field].wr_hi = 1'b0;
            next_st.ctr[cw.counter_select_field].out = (cw.mode != 3'h0); // RULE_06
          end
        end
      end
      else
      begin
        // count data into the reload register of the addressed counter
        unique case (st.ctr[wsel].fmt) // RULE_09 RULE_16
          tit_pkg::FMT_LSB:
          begin
            next_st.ctr[wsel].reload = {8'h00, st.bus_prev.data};
            next_st.ctr[wsel].pend = 1'b1;
          end
          tit_pkg::FMT_MSB:
          begin
            next_st.ctr[wsel].reload = {st.bus_prev.data, 8'h00};
            next_st.ctr[wsel].pend = 1'b1;
          end
          tit_pkg::FMT_WORD:
          begin
            if (!st.ctr[wsel].wr_hi)
            begin
              next_st.ctr[wsel].reload[7:0] = st.bus_prev.data;
              next_st.ctr[wsel].wr_hi = 1'b1;
              if (st.ctr[wsel].mode == 3'h0)
              begin
                next_st.ctr[wsel].armed = 1'b0; // first byte stops the count
              end
            end
            else
            begin
              next_st.ctr[wsel].reload[15:8] = st.bus_prev.data;
              next_st.ctr[wsel].wr_hi = 1'b0;
              next_st.ctr[wsel].pend = 1'b1;
            end
          end
          default:
          begin
            next_st.ctr[wsel].pend = st.ctr[wsel].pend; // unprogrammed counter
          end
        endcase
      end
    end

    // finished reads advance the byte pointer and release a latch
    if (rd_done && st.bus_prev.port_select != tit_pkg::PORT_CTRL)
    begin
      if (st.ctr[st.bus_prev.port_select].fmt == tit_pkg::FMT_WORD)
      begin
        next_st.ctr[st.bus_prev.port_select].rd_hi = !st.ctr[st.bus_prev.port_select].rd_hi;
      end
      if (st.ctr[st.bus_prev.port_select].fmt != tit_pkg::FMT_WORD
          || st.ctr[st.bus_prev.port_select].rd_hi)
      begin
        next_st.ctr[st.bus_prev.port_select].latched = 1'b0;
      end
    end

    // read data from latch when held, else live count
    rc = st.ctr[st.bus_s2.port_select];
    rv = rc.latched ? rc.latch : rc.count; // RULE_13
    if (rc.fmt == tit_pkg::FMT_MSB || (rc.fmt == tit_pkg::FMT_WORD && rc.rd_hi))
    begin
      next_st.rdata = rv[15:8];
    end
    else
    begin
      next_st.rdata = rv[7:0]; // RULE_07
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= '0;
      st.bus_s1 <= '1;
      st.bus_s2 <= '1;
      st.bus_prev <= '1;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pins

  assign o_data = st.rdata;
  assign o_data_oe = !st.bus_s2.cs_n && !st.bus_s2.rd_n && st.bus_s2.wr_n
                     && st.bus_s2.port_select != tit_pkg::PORT_CTRL; // RULE_10 RULE_12
  always_comb
  begin
    for (int j = 0; j < tit_pkg::NUM_CTR; j++)
    begin
      o_cnt_out[j] = st.ctr[j].out; // RULE_14
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  property p_cs_float;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    st.bus_s2.cs_n |-> !o_data_oe;
  endproperty
  a_cs_float: assert property (p_cs_float) else $error("bus driven while deselected"); // RULE_11

  property p_ctl_float;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st.bus_s2.port_select == tit_pkg::PORT_CTRL) |-> !o_data_oe;
  endproperty
  a_ctl_float: assert property (p_ctl_float) else $error("bus driven at control port"); // RULE_10

  property p_idle_float;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st.bus_s2.rd_n && st.bus_s2.wr_n) |-> !o_data_oe;
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("bus driven with no strobe"); // RULE_12

  property p_read_drive;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (!st.bus_s2.cs_n && !st.bus_s2.rd_n && st.bus_s2.wr_n
     && st.bus_s2.port_select != tit_pkg::PORT_CTRL) |-> o_data_oe;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("counter read not driven"); // RULE_07

  property p_ctrl_write;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (wr_done && wsel == tit_pkg::PORT_CTRL && cw.counter_select_field == 2'h0
     && cw.transfer_format_field != tit_pkg::FMT_LATCH)
    |=> st.ctr[0].mode == $past(cw.mode) && st.ctr[0].bcd == $past(cw.bcd);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control word not stored"); // RULE_04

  property p_load_lsb;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (wr_done && wsel == tit_pkg::PORT_CTR0 && st.ctr[0].fmt == tit_pkg::FMT_LSB)
    |=> st.ctr[0].reload == {8'h00, $past(st.bus_prev.data)} && st.ctr[0].pend;
  endproperty
  a_load_lsb: assert property (p_load_lsb) else $error("counter 0 load lost"); // RULE_09

  property p_latch_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st.ctr[0].latched && !wr_done) |=> $stable(st.ctr[0].latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched value moved"); // RULE_13

  property p_bcd_wrap;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (ev[0] && st.ctr[0].bcd && st.ctr[0].armed && st.ctr[0].mode == 3'h0
     && st.gate_s2[0] && !st.ctr[0].pend && !wr_done
     && st.ctr[0].count[3:0] == 4'h0 && st.ctr[0].count != 16'h0000)
    |=> st.ctr[0].count[3:0] == 4'h9;
  endproperty
  a_bcd_wrap: assert property (p_bcd_wrap) else $error("decade did not wrap to nine"); // RULE_17

  property p_term_out;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (ev[0] && st.ctr[0].mode == 3'h0 && st.ctr[0].armed && st.gate_s2[0]
     && !st.ctr[0].pend && !st.ctr[0].bcd && st.ctr[0].count == 16'h0001 && !wr_done)
    |=> o_cnt_out[0] ##1 o_cnt_out[0];
  endproperty
  a_term_out: assert property (p_term_out) else $error("time-out not signalled"); // RULE_14

  property p_edge_only;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !ev[0] |=> $stable(st.ctr[0].count);
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("count moved off clock edge"); // RULE_18

endmodule // tit_timer

/* File: test/tit_cpu_model.sv */
// processor bus model issuing port reads and writes to the timer
`timescale 1ns/100ps

module tit_cpu_model
(
  // reference clock
  input wire logic i_ref_clk,
  // data returned by the timer
  input wire logic [7:0] i_data,
  input wire logic i_data_oe,
  // processor pins
  output tit_pkg::tit_bus_t o_bus
);

  // all strobes idle at time zero
  initial o_bus = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, port_select: 2'h0, data: 8'h5A};

  //////////////////////////////////////////////////////////////////////////////
  // released data pins show a pattern that changes every cycle
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge i_ref_clk);
      o_bus.cs_n <= 1'b1;
      o_bus.data <= ~o_bus.data;
    end
  endtask

  // write strobe low six cycles; data held past the trailing edge
  task automatic bus_write(input logic cs_n, input logic [1:0] sel, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_bus <= '{cs_n: cs_n, rd_n: 1'b1, wr_n: 1'b0, port_select: sel, data: d};
    repeat (6) @(posedge i_ref_clk);
    o_bus.wr_n <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    idle(5);
  endtask

  // read strobe low ten cycles; byte taken at the last low edge
  task automatic bus_read(input logic cs_n, input logic [1:0] sel, output logic [7:0] d,
    output logic oe);
    @(posedge i_ref_clk);
    o_bus <= '{cs_n: cs_n, rd_n: 1'b0, wr_n: 1'b1, port_select: sel, data: ~o_bus.data};
    repeat (10)
    begin
      @(posedge i_ref_clk);
      o_bus.data <= ~o_bus.data;
    end
    d = i_data;
    oe = i_data_oe;
    o_bus.rd_n <= 1'b1;
    idle(6);
  endtask

endmodule // tit_cpu_model

/* File: test/triple_interval_timer_bus_port_tb.sv */
// self-checking bench for the triple interval timer
`timescale 1ns/100ps

module triple_interval_timer_bus_port_tb;

  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  tit_pkg::tit_bus_t bus;
  logic [7:0] rd_data;
  logic rd_oe;
  logic [2:0] cnt_clk = 3'h0;
  logic [2:0] gate = 3'h7;
  logic [2:0] cnt_out;
  logic [31:0] lfsr = 32'h98DC1731;
  int num_errors = 0;
  int total_checks = 0;
  logic [15:0] v0, v1;
  logic [7:0] b, bt, got;
  logic oe;
  int n;

  // reference clock
  always #2 ref_clk = ~ref_clk;

  tit_timer i_tit_timer (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_bus(bus),
    .o_data(rd_data), .o_data_oe(rd_oe), .i_cnt_clk(cnt_clk), .i_gate(gate),
    .o_cnt_out(cnt_out));

  tit_cpu_model i_tit_cpu_model (.i_ref_clk(ref_clk), .i_data(rd_data),
    .i_data_oe(rd_oe), .o_bus(bus));

  //////////////////////////////////////////////////////////////////////////////
  // random source and expectations
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    r = v;
    for (int d = 0; d < 4; d++)
    begin
      if (r[d*4 +: 4] != 4'h0)
      begin
        r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
        return r;
      end
      r[d*4 +: 4] = 4'h9;
    end
    return r;
  endfunction

  // count after k counter edges; the first edge only loads
  function automatic logic [15:0] exp_cnt(input logic [15:0] v, input int k, input logic bcd);
    logic [15:0] c;
    c = v;
    for (int j = 1; j < k; j++)
    begin
      c = bcd ? bcd_dec(c) : c - 16'h0001;
    end
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // compare, bus and counter clock helpers
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic ctl(input logic [1:0] c, input logic [1:0] f, input logic [2:0] m,
    input logic bcd);
    i_tit_cpu_model.bus_write(1'b0, tit_pkg::PORT_CTRL, {c, f, m, bcd});
  endtask

  task automatic load16(input logic [1:0] c, input logic [15:0] v);
    i_tit_cpu_model.bus_write(1'b0, c, v[7:0]);
    i_tit_cpu_model.bus_write(1'b0, c, v[15:8]);
  endtask

  task automatic rd8(input logic [1:0] c, output logic [7:0] d);
    i_tit_cpu_model.bus_read(1'b0, c, d, oe);
    check({15'h0000, oe}, 16'h0001);
  endtask

  task automatic rd16(input logic [1:0] c, input logic [15:0] e);
    logic [7:0] lo, hi;
    rd8(c, lo);
    rd8(c, hi);
    check({hi, lo}, e);
  endtask

  task automatic ticks(input logic [2:0] m, input int k);
    repeat (k)
    begin
      @(posedge ref_clk);
      cnt_clk <= cnt_clk | m;
      repeat (5) @(posedge ref_clk);
      cnt_clk <= cnt_clk & ~m;
      repeat (6) @(posedge ref_clk);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    end_sim;
  end

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check({13'h0000, cnt_out}, 16'h0000);
    check({15'h0000, rd_oe}, 16'h0000);
    // each channel times out a short random count in mode 0
    for (int i = 0; i < 3; i++)
    begin
      lfsr = lfsr_next(lfsr);
      n = 3 + int'(lfsr[1:0]);
      ctl(i[1:0], tit_pkg::FMT_WORD, 3'h0, 1'b0);
      load16(i[1:0], n[15:0]);
      ticks(3'h1 << i, n);
      check({15'h0000, cnt_out[i]}, 16'h0000);
      ticks(3'h1 << i, 1);
      check({15'h0000, cnt_out[i]}, 16'h0001);
    end
    // two channels side by side, read while counting
    lfsr = lfsr_next(lfsr);
    v0 = lfsr[15:0] | 16'h0100;
    v1 = lfsr[31:16] | 16'h0100;
    ctl(2'h0, tit_pkg::FMT_WORD, 3'h0, 1'b0);
    check({15'h0000, cnt_out[0]}, 16'h0000);
    ctl(2'h1, tit_pkg::FMT_WORD, 3'h0, 1'b0);
    load16(2'h0, v0);
    load16(2'h1, v1);
    ticks(3'h3, 1);
    ticks(3'h1, 3);
    rd16(2'h0, exp_cnt(v0, 4, 1'b0));
    rd16(2'h1, v1);
    ticks(3'h1, 2);
    rd16(2'h0, exp_cnt(v0, 6, 1'b0));
    // gate low holds the count
    @(posedge ref_clk);
    gate <= 3'h6;
    ticks(3'h1, 3);
    rd16(2'h0, exp_cnt(v0, 6, 1'b0));
    @(posedge ref_clk);
    gate <= 3'h7;
    // latched value stands until both bytes are read
    ctl(2'h0, tit_pkg::FMT_LATCH, 3'h0, 1'b0);
    ticks(3'h1, 2);
    rd16(2'h0, exp_cnt(v0, 6, 1'b0));
    rd16(2'h0, exp_cnt(v0, 8, 1'b0));
    // decimal count across a decade borrow
    ctl(2'h2, tit_pkg::FMT_WORD, 3'h0, 1'b1);
    load16(2'h2, 16'h0100);
    ticks(3'h4, 2);
    rd16(2'h2, exp_cnt(16'h0100, 2, 1'b1));
    // single byte formats
    lfsr = lfsr_next(lfsr);
    b = lfsr[7:0];
    bt = lfsr[15:8] | 8'h01;
    ctl(2'h1, tit_pkg::FMT_LSB, 3'h0, 1'b0);
    i_tit_cpu_model.bus_write(1'b0, 2'h1, b);
    ticks(3'h2, 1);
    rd8(2'h1, got);
    check({8'h00, got}, {8'h00, b});
    ctl(2'h1, tit_pkg::FMT_MSB, 3'h0, 1'b0);
    i_tit_cpu_model.bus_write(1'b0, 2'h1, bt);
    ticks(3'h2, 1);
    rd8(2'h1, got);
    check({8'h00, got}, {8'h00, bt});
    // refused accesses float the bus and change nothing
    i_tit_cpu_model.bus_read(1'b0, tit_pkg::PORT_CTRL, got, oe);
    check({15'h0000, oe}, 16'h0000);
    i_tit_cpu_model.bus_read(1'b1, 2'h0, got, oe);
    check({15'h0000, oe}, 16'h0000);
    i_tit_cpu_model.bus_write(1'b1, 2'h2, b);
    i_tit_cpu_model.bus_write(1'b1, tit_pkg::PORT_CTRL, 8'h90);
    ctl(tit_pkg::SEL_INVALID, tit_pkg::FMT_LSB, 3'h0, 1'b0);
    ticks(3'h4, 1);
    rd16(2'h2, exp_cnt(16'h0100, 3, 1'b1));
    // rate generator: output low for one clock at count one
    ctl(2'h2, tit_pkg::FMT_WORD, 3'h2, 1'b0);
    load16(2'h2, 16'h0003);
    ticks(3'h4, 3);
    check({15'h0000, cnt_out[2]}, 16'h0000);
    ticks(3'h4, 1);
    check({15'h0000, cnt_out[2]}, 16'h0001);
    end_sim;
  end

endmodule // triple_interval_timer_bus_port_tb
